//--- design/jtid_pkg.sv
// Constants, types and helpers shared by the scan access block
// Operation
// - After reset, each tile puts exactly two taps in the chain: boundary and chip.
// - Boundary tap follows the standard test-access scheme and scans the I/O pins.
// - Chip tap reaches tile, switch and one-time memory for code load and debug.
// - Test reset held low keeps the whole scan module in reset.
// - Identification word: version, part, maker, then bit 0 fixed at one.
// - User-code word: user ID, unused field, silicon revision, high to low.
// - User ID comes from tile 0 security bits 22 to 31, zero if unprogrammed.
// - Global reset is active low and resets the whole device.
// - After global reset release, wait for PLL lock, then start boot.
// - All scan activity follows the test clock; only test reset is exempt. Here global reset also clears the taps.
// - Security bits 31 to 22 extend the user ID reported in the user-code word.
package jtid_pkg;

  // ----------------------------------------------------------------
  // Widths and instruction codes
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_IDENT = 4'h1;
  localparam logic [IR_W-1:0] IR_USER = 4'h2;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h3;
  localparam logic [IR_W-1:0] IR_ACC_TILE = 4'h4;
  localparam logic [IR_W-1:0] IR_ACC_SWITCH = 4'h5;
  localparam logic [IR_W-1:0] IR_ACC_OTP = 4'h6;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;  // Low bits 01 as the standard asks

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ID_VER_LO = 28;
  localparam int ID_PART_LO = 12;
  localparam int ID_MAKER_LO = 1;
  localparam int UC_UID_HI = 31;
  localparam int UC_UID_LO = 22;
  localparam int UC_UNUSED_W = 6;
  localparam int SEC_UID_HI = 31;
  localparam int SEC_UID_LO = 22;
  localparam logic [DR_W-1:0] DR_RESET = 32'h0000_0000;
  localparam logic [1:0] TGT_TILE = 2'h0;
  localparam logic [1:0] TGT_SWITCH = 2'h1;
  localparam logic [1:0] TGT_OTP = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
    TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PAU_DR = 4'h6, TS_EX2_DR = 4'h7,
    TS_UPD_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SH_IR = 4'hB,
    TS_EX1_IR = 4'hC, TS_PAU_IR = 4'hD, TS_EX2_IR = 4'hE, TS_UPD_IR = 4'hF
  } jtid_tap_e;

  typedef enum logic [1:0] {
    BT_WAIT = 2'h0, BT_GO = 2'h1, BT_RUN = 2'h2
  } jtid_boot_e;

  // Scan pins after synchronisation
  typedef struct packed {
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
  } jtid_scan_s;

  // ----------------------------------------------------------------
  // Tap next-state function, shared by every tap in the chain
  // ----------------------------------------------------------------
  function automatic jtid_tap_e tap_next(input jtid_tap_e st, input logic tms);
    case (st)
      TS_RESET: tap_next = tms ? TS_RESET : TS_IDLE;
      TS_IDLE: tap_next = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: tap_next = tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: tap_next = tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: tap_next = tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: tap_next = tms ? TS_UPD_DR : TS_PAU_DR;
      TS_PAU_DR: tap_next = tms ? TS_EX2_DR : TS_PAU_DR;
      TS_EX2_DR: tap_next = tms ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: tap_next = tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: tap_next = tms ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: tap_next = tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: tap_next = tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: tap_next = tms ? TS_UPD_IR : TS_PAU_IR;
      TS_PAU_IR: tap_next = tms ? TS_EX2_IR : TS_PAU_IR;
      TS_EX2_IR: tap_next = tms ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: tap_next = tms ? TS_SEL_DR : TS_IDLE;
      default: tap_next = TS_RESET;
    endcase
  endfunction

  // Private instructions of each tap kind
  function automatic logic is_priv(input logic chip, input logic [IR_W-1:0] ir);
    if (chip) begin
      is_priv = (ir == IR_ACC_TILE) || (ir == IR_ACC_SWITCH) || (ir == IR_ACC_OTP);
    end else begin
      is_priv = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
    end
  endfunction

endpackage

//--- design/jtid_sync.sv
// Two-stage synchroniser bank for inputs from outside the clock domain
`timescale 1ns/10ps
module jtid_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

//--- design/jtid_top.sv
// Scan access block: tap chain, identity words, boundary and chip access, boot release
`timescale 1ns/10ps
module jtid_top #(
  parameter int NUM_TILES = 2,
  parameter logic [3:0] ID_VERSION = 4'h0,  // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h00A5,  // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h055,  // Arbitrary value
  parameter logic [15:0] SIL_REV = 16'h0001  // Arbitrary value
) (
  // System clock and global reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Scan pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_N,
  output logic TDO,
  output logic TDO_OE,
  // Boot release
  input wire logic PLL_LOCK,
  output logic BOOT_START,
  output logic BOOT_RUN,
  // Tile 0 security register
  input wire logic [jtid_pkg::DR_W-1:0] SEC_REG_T0,
  // Boundary scan of the pins, one word per tile
  input wire logic [NUM_TILES*jtid_pkg::DR_W-1:0] PIN_IN,
  output logic [NUM_TILES*jtid_pkg::DR_W-1:0] PIN_OUT,
  output logic [NUM_TILES-1:0] PIN_EXT,
  // Chip access, one channel per tile
  output logic [NUM_TILES-1:0] ACC_WR,
  output logic [NUM_TILES*2-1:0] ACC_TGT,
  output logic [NUM_TILES*jtid_pkg::DR_W-1:0] ACC_WDATA,
  input wire logic [NUM_TILES*jtid_pkg::DR_W-1:0] ACC_RDATA
);
  import jtid_pkg::*;

  localparam int NT = 2 * NUM_TILES;

  // ----------------------------------------------------------------
  // Pin synchronisation and test clock edges
  // ----------------------------------------------------------------
  jtid_scan_s scan_raw;
  jtid_scan_s scan_s;
  logic lock_s;
  logic [NUM_TILES*DR_W-1:0] pin_in_s;
  logic tck_prev_q;

  assign scan_raw = '{trst_n: TRST_N, tck: TCK, tms: TMS, tdi: TDI};

  jtid_sync #(
    .W($bits(jtid_scan_s) + 1)
  ) u_sync_scan (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({scan_raw, PLL_LOCK}),
    .q({scan_s, lock_s})
  );

  // Pins are slow next to the scan clock, so a plain two-stage bank is enough
  jtid_sync #(
    .W(NUM_TILES * DR_W)
  ) u_sync_pins (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d(PIN_IN),
    .q(pin_in_s)
  );

  // Edge finder runs off the second stage only
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= scan_s.tck;
    end
  end

  wire tck_rise = scan_s.tck & ~tck_prev_q;
  wire tck_fall = ~scan_s.tck & tck_prev_q;
  // Either reset clears the taps; a tied-low test reset parks them for good
  wire tap_rst = !RST_N || !scan_s.trst_n;

  // ----------------------------------------------------------------
  // Identity words
  // ----------------------------------------------------------------
  wire [DR_W-1:0] id_word = (DR_W'(ID_VERSION) << ID_VER_LO) | (DR_W'(ID_PART) << ID_PART_LO)
                          | (DR_W'(ID_MAKER) << ID_MAKER_LO) | DR_W'(1);
  // Unprogrammed security bits are zero, so the user ID reads zero there
  wire [DR_W-1:0] uc_word = {SEC_REG_T0[SEC_UID_HI:SEC_UID_LO], {UC_UNUSED_W{1'b0}}, SIL_REV};

  // ----------------------------------------------------------------
  // Tap chain: even taps scan the pins, odd taps reach the tile
  // ----------------------------------------------------------------
  logic [NT:0] chain;
  logic [NT-1:0] oe;

  assign chain[0] = scan_s.tdi;

  genvar g;
  for (g = 0; g < NT; g++) begin : g_tap
    localparam bit IS_CHIP = (g % 2) == 1;
    localparam int TILE = g / 2;
    jtid_tap_e st_q;
    logic [IR_W-1:0] ir_q;
    logic [IR_W-1:0] ir_sh_q;
    logic [DR_W-1:0] dr_q;
    logic tdo_q;
    logic oe_q;

    // Instruction decode and capture selection
    wire priv = is_priv(IS_CHIP, ir_q);
    wire sel_id = ir_q == IR_IDENT;
    wire sel_uc = ir_q == IR_USER;
    wire bypass = !(sel_id || sel_uc || priv);
    wire [DR_W-1:0] priv_cap = IS_CHIP ? ACC_RDATA[TILE*DR_W +: DR_W]
                                       : pin_in_s[TILE*DR_W +: DR_W];
    wire [DR_W-1:0] cap_val = sel_id ? id_word : sel_uc ? uc_word : priv ? priv_cap : DR_RESET;
    wire upd_dr = tck_fall && (st_q == TS_UPD_DR) && priv;
    wire shifting = (st_q == TS_SH_IR) || (st_q == TS_SH_DR);

    // State, instruction shift and capture on rising test clock; instruction update on falling
    always_ff @(posedge CLK_SYS) begin
      if (tap_rst) begin
        st_q <= TS_RESET;
        ir_q <= IR_IDENT;
        ir_sh_q <= '0;
        dr_q <= DR_RESET;
      end else if (tck_rise) begin
        st_q <= tap_next(st_q, scan_s.tms);
        case (st_q)
          TS_RESET: ir_q <= IR_IDENT;
          TS_CAP_IR: ir_sh_q <= IR_CAPTURE;
          TS_SH_IR: ir_sh_q <= {chain[g], ir_sh_q[IR_W-1:1]};
          TS_CAP_DR: dr_q <= cap_val;
          TS_SH_DR: dr_q <= bypass ? {dr_q[DR_W-1:1], chain[g]} : {chain[g], dr_q[DR_W-1:1]};
          default: ;
        endcase
      end else if (tck_fall && st_q == TS_UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end

    // Serial out and its enable move on the falling edge, half a period clear of sampling
    always_ff @(posedge CLK_SYS) begin
      if (tap_rst) begin
        tdo_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (tck_fall) begin
        tdo_q <= (st_q == TS_SH_IR) ? ir_sh_q[0] : dr_q[0];
        oe_q <= shifting;
      end
    end

    assign chain[g+1] = tdo_q;
    assign oe[g] = oe_q;

    if (IS_CHIP) begin : g_chip
      logic wr_q;
      logic [1:0] tgt_q;
      logic [DR_W-1:0] wdata_q;
      wire [1:0] tgt_sel = (ir_q == IR_ACC_SWITCH) ? TGT_SWITCH
                         : (ir_q == IR_ACC_OTP) ? TGT_OTP : TGT_TILE;

      // Update of an access word hands it to tile, switch or one-time memory
      always_ff @(posedge CLK_SYS) begin
        if (tap_rst) begin
          wr_q <= 1'b0;
          tgt_q <= TGT_TILE;
          wdata_q <= DR_RESET;
        end else begin
          wr_q <= upd_dr;
          if (upd_dr) begin
            tgt_q <= tgt_sel;
            wdata_q <= dr_q;
          end
        end
      end

      assign ACC_WR[TILE] = wr_q;
      assign ACC_TGT[TILE*2 +: 2] = tgt_q;
      assign ACC_WDATA[TILE*DR_W +: DR_W] = wdata_q;
    end else begin : g_bnd
      logic [DR_W-1:0] pin_q;
      logic ext_q;

      // Preload and test drive of the pins; the mode flag follows the instruction
      always_ff @(posedge CLK_SYS) begin
        if (tap_rst) begin
          pin_q <= DR_RESET;
          ext_q <= 1'b0;
        end else begin
          ext_q <= ir_q == IR_EXTEST;
          if (upd_dr) begin
            pin_q <= dr_q;
          end
        end
      end

      assign PIN_OUT[TILE*DR_W +: DR_W] = pin_q;
      assign PIN_EXT[TILE] = ext_q;
    end
  end

  // Last tap in the chain drives the pin
  assign TDO = chain[NT];
  assign TDO_OE = oe[NT-1];

  // ----------------------------------------------------------------
  // Boot release after global reset
  // ----------------------------------------------------------------
  jtid_boot_e bt_q;
  jtid_boot_e bt_d;
  logic start_q;
  logic run_q;

  // Boot waits on lock; a lost lock later does not restart boot, only reset does
  always_comb begin
    case (bt_q)
      BT_WAIT: bt_d = lock_s ? BT_GO : BT_WAIT;
      BT_GO: bt_d = BT_RUN;
      BT_RUN: bt_d = BT_RUN;
      default: bt_d = BT_WAIT;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      bt_q <= BT_WAIT;
      start_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      bt_q <= bt_d;
      start_q <= bt_d == BT_GO;
      run_q <= bt_d != BT_WAIT;
    end
  end

  assign BOOT_START = start_q;
  assign BOOT_RUN = run_q;

endmodule

//--- bench/jtid_host.sv
// Scan host model that drives the test pins of the block
`timescale 1ns/10ps
module jtid_host (
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  // Test clock stands low between frames; test reset starts low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
  end
  // Test reset level; only changed while the test clock is low
  task automatic set_trst(input logic v);
    trst_n = v;
  endtask
  // One test clock period: mode and data set while low, reply taken at the rise
  task automatic tick(input logic ms, input logic di, output logic dout);
    tms = ms;
    tdi = di;
    #32 tck = 1'b1;
    dout = tdo;
    #32 tck = 1'b0;
  endtask
  // Run-idle, capture, n shifted bits LSB first, update, back to run-idle
  task automatic shift(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask
endmodule

//--- bench/jtid_chk.sv
// Port-level assertions for the scan access block
`timescale 1ns/10ps
module jtid_chk #(
  parameter int NUM_TILES = 2
) (
  // Watched ports
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic PLL_LOCK,
  input wire logic BOOT_START,
  input wire logic BOOT_RUN,
  input wire logic [NUM_TILES-1:0] PIN_EXT,
  input wire logic [NUM_TILES-1:0] ACC_WR,
  input wire logic [NUM_TILES*2-1:0] ACC_TGT
);
  // One domain, so clock and reset are given once
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  boot_pulse_a: assert property (BOOT_START |=> !BOOT_START)
    else $error("boot start longer than one cycle");
  boot_run_a: assert property (BOOT_START |-> BOOT_RUN)
    else $error("boot run low at boot start");
  run_hold_a: assert property (BOOT_RUN |=> BOOT_RUN)
    else $error("boot run dropped without reset");
  lock_wait_a: assert property (!PLL_LOCK [*4] |=> !BOOT_START)
    else $error("boot started without lock");
  lock_boot_a: assert property ($rose(PLL_LOCK) && !BOOT_RUN |-> ##[1:6] BOOT_START)
    else $error("boot did not start after lock");
  // Reset is the cause here, so it cannot also disable the check
  reset_quiet_a: assert property (disable iff (1'b0) !RST_N |=> !BOOT_RUN && !TDO_OE
    && PIN_EXT == '0 && ACC_WR == '0)
    else $error("outputs active after global reset");
  trst_quiet_a: assert property (!TRST_N [*6] |-> PIN_EXT == '0 && ACC_WR == '0)
    else $error("scan outputs active in test reset");
  acc_pulse_a: assert property (ACC_WR != '0 |=> ACC_WR == '0)
    else $error("access strobe longer than one cycle");
  tgt_legal_a: assert property (ACC_WR[0] |-> ACC_TGT[1:0] != 2'h3)
    else $error("access target out of range");
  // Output may only move in the low half of the test clock
  tdo_edge_a: assert property ($changed(TDO) || $changed(TDO_OE) |-> !TCK)
    else $error("serial output moved while test clock high");
endmodule
bind jtid_top jtid_chk #(.NUM_TILES(NUM_TILES)) u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .TCK(TCK),
  .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .PLL_LOCK(PLL_LOCK), .BOOT_START(BOOT_START),
  .BOOT_RUN(BOOT_RUN), .PIN_EXT(PIN_EXT), .ACC_WR(ACC_WR), .ACC_TGT(ACC_TGT));

//--- bench/jtid_top_tb.sv
// Self-checking bench for the scan access block
`timescale 1ns/10ps
module jtid_top_tb;
  import jtid_pkg::*;
  localparam logic [3:0] VER = 4'h3;  // Arbitrary value
  localparam logic [15:0] PART = 16'h0C3A;  // Arbitrary value
  localparam logic [10:0] MAKER = 11'h2B1;  // Arbitrary value
  localparam logic [15:0] REV = 16'h0042;  // Arbitrary value
  localparam logic [31:0] SEC = 32'hB400_1234;
  localparam logic [31:0] RD = 32'h5A5A_0F0F;
  localparam logic [31:0] WD = 32'hC0DE_1234;
  localparam logic [31:0] RD2 = 32'h1E2D_3C4B;
  localparam logic [31:0] WD2 = 32'h6B7A_8998;
  localparam logic [31:0] PINW = 32'h3C96_A50F;
  localparam logic [31:0] PV = 32'h0F1E_2D3C;
  localparam logic [31:0] PV2 = 32'h7C3A_19E4;
  localparam logic [31:0] IDW = {VER, PART, MAKER, 1'b1};
  localparam logic [31:0] UCW = {SEC[31:22], 6'h00, REV};
  logic clk_sys, rst_n, pll_lock, tck, tms, tdi, trst_n, tdo, tdo_oe, boot_start, boot_run;
  logic [63:0] pin_out, acc_wdata;
  logic [1:0] pin_ext, acc_wr;
  logic [3:0] acc_tgt;
  logic [127:0] got;
  logic [63:0] pin_in;
  logic [1:0] wr_seen = 2'b00;
  logic oe_seen = 1'b0;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  jtid_top #(.NUM_TILES(2), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .SIL_REV(REV)) dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n), .TDO(tdo),
    .TDO_OE(tdo_oe), .PLL_LOCK(pll_lock), .BOOT_START(boot_start), .BOOT_RUN(boot_run),
    .SEC_REG_T0(SEC), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_EXT(pin_ext), .ACC_WR(acc_wr),
    .ACC_TGT(acc_tgt), .ACC_WDATA(acc_wdata), .ACC_RDATA({RD2, RD}));
  jtid_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard, and a sticky flag because the access strobe lasts one cycle
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    wr_seen <= wr_seen | acc_wr;
    if (tdo_oe) oe_seen <= 1'b1;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Host walks are started on a falling edge so test clock edges never meet a rising edge
  initial begin
    rst_n = 1'b0;
    pll_lock = 1'b0;
    pin_in = {32'h0000_0000, PINW};
    // Held for 100 ns, twenty cycles, longer than the usual five, as the host must
    repeat (20) @(negedge clk_sys);
    chk({boot_run, tdo_oe, pin_ext, acc_wr}, '0);
    rst_n = 1'b1;
    repeat (25) @(negedge clk_sys);
    host.set_trst(1'b1);
    repeat (10) @(negedge clk_sys);
    chk(boot_run, 1'b0);
    pll_lock = 1'b1;
    for (int i = 0; i < 10 && boot_start !== 1'b1; i++) @(negedge clk_sys);
    chk(boot_start, 1'b1);
    @(negedge clk_sys);
    chk({boot_start, boot_run}, 2'b01);
    host.tick(1'b0, 1'b0, got[0]);
    host.shift(1'b0, 128, '0, got);
    chk(got, {4{IDW}});
    chk({oe_seen, tdo_oe}, 2'b10);
    host.shift(1'b1, 16, 128'h2222, got);
    chk(got, 128'h1111);
    host.shift(1'b0, 128, '0, got);
    chk(got, {4{UCW}});
    // Access on tile 0 chip tap only, the other three taps in bypass
    host.shift(1'b1, 16, 128'hF4FF, got);
    host.shift(1'b0, 35, {1'b0, WD, 2'b00}, got);
    chk(got, {1'b0, RD, 2'b00});
    chk({wr_seen[0], acc_tgt[1:0], acc_wdata[31:0]}, {1'b1, TGT_TILE, WD});
    // Tile 1 chip tap to the switch and tile 0 boundary tap sampling, in one pass
    host.shift(1'b1, 16, 128'h3FF5, got);
    host.shift(1'b0, 66, {PV2, 2'b00, WD2}, got);
    chk(got, {PINW, 2'b00, RD2});
    chk({wr_seen[1], acc_tgt[3:2], acc_wdata[63:32]}, {1'b1, TGT_SWITCH, WD2});
    chk({pin_out[31:0], pin_ext}, {PV2, 2'b00});
    // Tile 0 chip tap to the one-time memory
    host.shift(1'b1, 16, 128'hF6FF, got);
    host.shift(1'b0, 35, {1'b0, PV, 2'b00}, got);
    chk(got, {1'b0, RD, 2'b00});
    chk({acc_tgt[1:0], acc_wdata[31:0]}, {TGT_OTP, PV});
    host.shift(1'b1, 16, 128'h0FFF, got);
    repeat (4) @(negedge clk_sys);
    chk(pin_ext, 2'b01);
    // Test drive: pins captured on the way in, drive word loaded at update
    host.shift(1'b0, 35, {PV, 3'b000}, got);
    chk(got, {PINW, 3'b000});
    chk(pin_out[31:0], PV);
    // Test reset in mid-run: a clock pulse meanwhile must be ignored
    host.set_trst(1'b0);
    repeat (8) @(negedge clk_sys);
    chk({pin_ext, pin_out[31:0]}, '0);
    host.tick(1'b0, 1'b0, got[0]);
    host.set_trst(1'b1);
    repeat (6) @(negedge clk_sys);
    host.tick(1'b0, 1'b0, got[0]);
    host.shift(1'b0, 128, '0, got);
    chk(got, {4{IDW}});
    end_sim();
  end
endmodule
